// File: ufsm_pkg.sv
// Purpose: Shared types and constants for the user-side layer-1 fault state machine
// Assumes: SDH overhead bits numbered 1 (MSB) to 8 (LSB) within each byte
// Notes: One-hot state codes; error and correction parameters are one bit each
`default_nettype none
package ufsm_pkg;

  // One-hot states of the user-side machine
  typedef enum logic [7:0] {
    user_power_off             = 8'h01,
    user_operational           = 8'h02,
    upstream_access_fault      = 8'h04,
    downstream_link_fault      = 8'h08,
    downstream_access_fault    = 8'h10,
    upstream_link_fault        = 8'h20,
    combined_access_link_fault = 8'h40,
    user_power_on              = 8'h80
  } ufsm_state_e;

  localparam ufsm_state_e UFSM_RESET_STATE = user_power_off;

  // Overhead field positions and codes
  localparam int unsigned UFSM_K2_MS_LSB = 0;        // K2 bits 6..8 sit at [2:0]
  localparam logic [2:0] UFSM_MS_RDI_CODE = 3'h6;    // Pattern 110
  localparam logic [2:0] UFSM_K2_IDLE_CODE = 3'h0;
  localparam int unsigned UFSM_G1_RDI_POS = 3;       // G1 bit 5 sits at [3]

  // Indication parameter numbers (bit positions in the parameter vectors)
  localparam int unsigned UFSM_PRM_POWER = 0;
  localparam int unsigned UFSM_PRM_UP_ACCESS = 1;
  localparam int unsigned UFSM_PRM_DOWN_IFACE = 2;
  localparam int unsigned UFSM_PRM_DOWN_ACCESS = 3;
  localparam int unsigned UFSM_PRM_UP_IFACE = 4;
  localparam int unsigned UFSM_PRM_W = 5;
  localparam logic [4:0] UFSM_PRM_NONE = 5'h00;

  // Synchroniser depth and reset level of the power-good pin
  localparam int unsigned UFSM_SYNC_STAGES = 2;
  localparam logic UFSM_SYNC_RST_VAL = 1'b0;

  // Defect levels from the receive-side detectors
  typedef struct packed {
    logic los;
    logic lof;
    logic lcd;
    logic lop;
    logic path_ais;
    logic apid_mismatch;
  } ufsm_defect_s;

  // Maintenance signal selection towards the interface
  typedef struct packed {
    logic tx_on;
    logic [2:0] k2_bits;
    logic g1_rdi;
  } ufsm_tx_s;

  // Management entity primitives
  typedef struct packed {
    logic activate;
    logic [4:0] error;
    logic [4:0] correction;
  } ufsm_mgmt_s;

  // Upper layer primitives
  typedef struct packed {
    logic active;
    logic deactive;
  } ufsm_upper_s;

  localparam ufsm_tx_s UFSM_TX_RESET = '{tx_on: 1'b0, k2_bits: 3'h0, g1_rdi: 1'b0};
  localparam ufsm_mgmt_s UFSM_MGMT_IDLE = '{activate: 1'b0, error: 5'h00, correction: 5'h00};
  localparam ufsm_upper_s UFSM_UPPER_IDLE = '{active: 1'b0, deactive: 1'b0};

endpackage
`default_nettype wire

// File: ufsm_sync2.sv
// Purpose: Two-stage synchroniser for asynchronous level inputs
// Assumes: Inputs are slow levels; no pulse shorter than two clocks
// Notes: Only the second stage is visible outside
`default_nettype none
module ufsm_sync2
  import ufsm_pkg::*;
#(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_r;

  // Two flip-flops in series; first stage read only by the second
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= {W{UFSM_SYNC_RST_VAL}};
      o_sync <= {W{UFSM_SYNC_RST_VAL}};
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule
`default_nettype wire

// File: ufsm_fault_fsm.sv
// Purpose: User-side layer-1 operation and maintenance state machine
// Assumes: Defect levels and overhead bytes come from logic on i_ref_clk
// Notes: Power-good is a pin and is synchronised; all outputs are registered
`default_nettype none
module ufsm_fault_fsm
  import ufsm_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Power control
  input wire logic i_power_good,
  input wire logic i_powerdown,
  // Receive-side detection
  input wire ufsm_defect_s i_defect,
  input wire logic i_apid_check_en,
  input wire logic [7:0] i_rx_k2,
  input wire logic [7:0] i_rx_g1,
  input wire logic i_rx_frame_ok,
  // State and transmit selection
  output ufsm_state_e o_state,
  output ufsm_tx_s o_tx,
  // Management and upper layer primitives
  output ufsm_mgmt_s o_mgmt,
  output ufsm_upper_s o_upper
);

  logic pwr_sync;
  ufsm_state_e state_r;
  ufsm_state_e state_nxt;
  ufsm_mgmt_s mgmt_nxt;
  ufsm_upper_s upper_nxt;
  ufsm_tx_s tx_nxt;

  // Power-good pin crossing
  ufsm_sync2 #(
    .W(1)
  ) u_pwr_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_power_good),
    .o_sync(pwr_sync)
  );

  // Maintenance signal for a given state
  function automatic ufsm_tx_s tx_for(input ufsm_state_e st);
    ufsm_tx_s t;
    t = UFSM_TX_RESET;
    case (st)
      user_operational, upstream_access_fault, upstream_link_fault: begin
        t.tx_on = 1'b1;
      end
      downstream_access_fault, combined_access_link_fault: begin
        t.tx_on = 1'b1;
        t.g1_rdi = 1'b1;
      end
      downstream_link_fault: begin
        t.tx_on = 1'b1;
        t.k2_bits = UFSM_MS_RDI_CODE;
        t.g1_rdi = 1'b1;
      end
      default: begin
        t = UFSM_TX_RESET;
      end
    endcase
    return t;
  endfunction

  // Received maintenance signals
  logic ms_rdi;
  logic p_rdi;
  logic lcd_eff;
  assign ms_rdi = (i_rx_k2[UFSM_K2_MS_LSB +: 3] == UFSM_MS_RDI_CODE);
  assign p_rdi = i_rx_g1[UFSM_G1_RDI_POS];
  assign lcd_eff = i_defect.lcd | (i_apid_check_en & i_defect.apid_mismatch);

  // Fault conditions
  logic fc_down_iface;
  logic fc_down_access;
  logic fc_up_iface;
  logic fc_up_access;
  logic fc_combined;
  assign fc_down_iface = i_defect.los | i_defect.lof;
  // path AIS taken as a detector level
  assign fc_down_access = lcd_eff | i_defect.lop | i_defect.path_ais;
  assign fc_up_iface = ms_rdi & p_rdi;
  assign fc_up_access = p_rdi & ~ms_rdi;
  assign fc_combined = (i_defect.path_ais & ms_rdi) | (lcd_eff & ms_rdi & p_rdi) | (i_defect.lop & ms_rdi);

  // Prioritised events, one at most per cycle
  logic pwr_loss;
  logic pwr_ok;
  logic ev_down_iface;
  logic ev_combined;
  logic ev_down_access;
  logic ev_up_iface;
  logic ev_up_access;
  logic ev_normal;
  assign pwr_loss = ~pwr_sync | i_powerdown;
  assign pwr_ok = ~pwr_loss;
  assign ev_down_iface = fc_down_iface;
  assign ev_combined = ~fc_down_iface & fc_combined;
  assign ev_down_access = ~fc_down_iface & ~fc_combined & fc_down_access;
  assign ev_up_iface = ~fc_down_iface & ~fc_down_access & fc_up_iface;
  assign ev_up_access = ~fc_down_iface & ~fc_down_access & fc_up_access;
  assign ev_normal = i_rx_frame_ok & ~fc_down_iface & ~fc_down_access & ~p_rdi & ~ms_rdi;

  // State decodes
  logic in_oper;
  logic in_pon;
  assign in_oper = (state_r == user_operational);
  assign in_pon = (state_r == user_power_on);

  // Next state and primitive selection
  always_comb begin
    state_nxt = state_r;
    mgmt_nxt = UFSM_MGMT_IDLE;
    upper_nxt = UFSM_UPPER_IDLE;
    if (state_r == user_power_off) begin
      if (pwr_ok) begin
        state_nxt = user_power_on;
      end
    end else if (pwr_loss) begin
      state_nxt = user_power_off;
      mgmt_nxt.error[UFSM_PRM_POWER] = 1'b1;
      upper_nxt.deactive = in_oper;
    end else if (ev_down_iface) begin
      if (state_r != downstream_link_fault) begin
        state_nxt = downstream_link_fault;
        mgmt_nxt.error[UFSM_PRM_DOWN_IFACE] = 1'b1;
        upper_nxt.deactive = in_oper;
      end
    end else if (ev_normal) begin
      if (!in_oper) begin
        state_nxt = user_operational;
        mgmt_nxt.activate = 1'b1;
        upper_nxt.active = 1'b1;
        case (state_r)
          upstream_access_fault: mgmt_nxt.correction[UFSM_PRM_UP_ACCESS] = 1'b1;
          downstream_link_fault: mgmt_nxt.correction[UFSM_PRM_DOWN_IFACE] = 1'b1;
          downstream_access_fault: mgmt_nxt.correction[UFSM_PRM_DOWN_ACCESS] = 1'b1;
          upstream_link_fault: mgmt_nxt.correction[UFSM_PRM_UP_IFACE] = 1'b1;
          combined_access_link_fault: begin
            mgmt_nxt.correction[UFSM_PRM_DOWN_ACCESS] = 1'b1;
            mgmt_nxt.correction[UFSM_PRM_UP_IFACE] = 1'b1;
          end
          default: mgmt_nxt.correction = UFSM_PRM_NONE;
        endcase
      end
    end else if (state_r == downstream_link_fault) begin
      state_nxt = downstream_link_fault;
    end else if (ev_combined) begin
      if (state_r != combined_access_link_fault) begin
        state_nxt = combined_access_link_fault;
        upper_nxt.deactive = in_oper;
        mgmt_nxt.error[UFSM_PRM_DOWN_ACCESS] = (state_r != downstream_access_fault);
        mgmt_nxt.error[UFSM_PRM_UP_IFACE] = (state_r != upstream_link_fault);
      end
    end else if (ev_down_access) begin
      if (state_r != downstream_access_fault && state_r != combined_access_link_fault) begin
        state_nxt = downstream_access_fault;
        mgmt_nxt.error[UFSM_PRM_DOWN_ACCESS] = 1'b1;
        upper_nxt.deactive = in_oper;
      end
    end else if (ev_up_iface) begin
      if (state_r != upstream_link_fault && state_r != combined_access_link_fault) begin
        state_nxt = upstream_link_fault;
        mgmt_nxt.error[UFSM_PRM_UP_IFACE] = 1'b1;
        upper_nxt.deactive = in_oper;
      end
    end else if (ev_up_access) begin
      if (in_oper || in_pon) begin
        state_nxt = upstream_access_fault;
        mgmt_nxt.error[UFSM_PRM_UP_ACCESS] = 1'b1;
        upper_nxt.deactive = in_oper;
      end
    end
  end

  assign tx_nxt = tx_for(state_nxt);

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= UFSM_RESET_STATE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mgmt <= UFSM_MGMT_IDLE;
      o_upper <= UFSM_UPPER_IDLE;
      o_tx <= UFSM_TX_RESET;
    end else begin
      o_mgmt <= mgmt_nxt;
      o_upper <= upper_nxt;
      o_tx <= tx_nxt;
    end
  end

  assign o_state = state_r;

  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  a_one_hot_state: assert property ($onehot(state_r))
    else $error("state register not one-hot");

  a_power_loss_off: assert property ((state_r != user_power_off && pwr_loss) |=>
    (state_r == user_power_off && o_mgmt.error == 5'h01 && o_upper.deactive == $past(in_oper)))
    else $error("power loss handling wrong");

  a_power_return_on: assert property ((state_r == user_power_off && pwr_ok) |=>
    (state_r == user_power_on && o_mgmt == UFSM_MGMT_IDLE && o_upper == UFSM_UPPER_IDLE))
    else $error("power return handling wrong");

  a_normal_reentry: assert property ((state_r != user_power_off && !in_oper && pwr_ok && ev_normal) |=>
    (state_r == user_operational && o_mgmt.activate && o_upper.active))
    else $error("operational re-entry wrong");

  a_rdi_alone_entry: assert property ((in_oper && pwr_ok && ev_up_access) |=>
    (state_r == upstream_access_fault && o_mgmt.error == 5'h02 && o_upper.deactive))
    else $error("path RDI alone handling wrong");

  a_link_fault_entry: assert property ((state_r != user_power_off && pwr_ok && fc_down_iface) |=>
    (state_r == downstream_link_fault))
    else $error("LOS/LOF did not take priority");

  a_link_fault_hold: assert property ((state_r == downstream_link_fault && pwr_ok && !ev_normal) |=>
    (state_r == downstream_link_fault && o_mgmt.error == UFSM_PRM_NONE))
    else $error("link fault state left on other fault");

  a_comb_from_access: assert property ((state_r == downstream_access_fault && pwr_ok && ev_combined) |=>
    (state_r == combined_access_link_fault && o_mgmt.error == 5'h10))
    else $error("combined entry parameters wrong");

  a_access_no_rdi: assert property ((state_r == downstream_access_fault && pwr_ok && fc_down_access &&
    !fc_down_iface && !fc_combined) |=> (state_r == downstream_access_fault && !o_mgmt.error[1]))
    else $error("path RDI seen during access fault");

  a_tx_link_fault: assert property ((state_r == downstream_link_fault) |->
    (o_tx.tx_on && o_tx.k2_bits == UFSM_MS_RDI_CODE && o_tx.g1_rdi))
    else $error("link fault transmit wrong");

  a_tx_silent: assert property ((state_r == user_power_off || state_r == user_power_on) |->
    (!o_tx.tx_on))
    else $error("signal sent while powered off or on");

  a_pulse_single: assert property ((o_upper.active || o_mgmt.activate) |=>
    (!o_upper.active && !o_mgmt.activate))
    else $error("activate pulse longer than one cycle");

  c_power_up_oper: cover property ((state_r == user_power_on) ##1 (state_r == user_operational));
  c_oper_link_fault: cover property ((in_oper) ##1 (state_r == downstream_link_fault));
  c_comb_entry: cover property ((state_r == upstream_link_fault) ##1 (state_r == combined_access_link_fault));
  c_oper_rdi: cover property ((in_oper) ##1 (state_r == upstream_access_fault));

endmodule
`default_nettype wire

// File: ufsm_net_model.sv
// Purpose: Network-side model feeding received overhead and defect levels
// Assumes: Bench changes the mode just after a rising clock edge
// Notes: Mode 0 normal, 1 RDI, 2 LOS, 3 LOP, 4 MS-RDI+RDI, 5 AIS+MS-RDI, 6 idle, 7 id mismatch
// Notes: With i_alt high, 2 gives LOF, 3 gives LOP+RDI, 7 gives LCD+MS-RDI+RDI
`default_nettype none
module ufsm_net_model
  import ufsm_pkg::*;
(
  // Scenario select
  input wire logic [2:0] i_mode,
  input wire logic i_alt,
  // Towards the user side
  output ufsm_defect_s o_defect,
  output logic [7:0] o_k2,
  output logic [7:0] o_g1,
  output logic o_frame_ok
);
  // Mode decode; LOS carries garbage overhead on purpose
  wire logic m_los = (i_mode == 3'h2) && !i_alt;
  wire logic m_lof = (i_mode == 3'h2) && i_alt;
  wire logic m_lcd = (i_mode == 3'h7) && i_alt;
  wire logic m_ms = (i_mode == 3'h2) || (i_mode == 3'h4) || (i_mode == 3'h5) || m_lcd;
  wire logic m_rdi = (i_mode == 3'h2) || (i_mode == 3'h1) || (i_mode == 3'h4) || m_lcd || ((i_mode == 3'h3) && i_alt);

  assign o_k2 = {5'h15, m_ms ? UFSM_MS_RDI_CODE : UFSM_K2_IDLE_CODE};
  assign o_g1 = {4'hA, m_rdi, 3'h5};
  assign o_defect = '{los: m_los, lof: m_lof, lcd: m_los || m_lcd, lop: (i_mode == 3'h3), path_ais: (i_mode == 3'h5),
    apid_mismatch: (i_mode == 3'h7) && !i_alt};
  // Frames stop when idle or lost
  assign o_frame_ok = (i_mode != 3'h6) && (i_mode != 3'h2);
endmodule
`default_nettype wire

// File: tb.sv
// Purpose: Self-checking bench for the user-side fault state machine
// Assumes: Partner model supplies received overhead and defects
// Notes: Table rows first, then reset, power pin and detector variant cases by hand
`default_nettype none
module tb
  import ufsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // Row of stimulus and expected outcome
  typedef struct packed {
    logic [2:0] m;
    logic p;
    ufsm_state_e st;
    logic [4:0] err;
    logic [4:0] cor;
    logic act;
    logic dea;
  } ufsm_row_s;

  logic clk, rst_b, pg, pd, apid_en;
  logic [2:0] mode;
  logic alt;
  ufsm_defect_s defect;
  logic [7:0] k2, g1;
  logic frame_ok;
  ufsm_state_e state;
  ufsm_tx_s tx;
  ufsm_mgmt_s mgmt;
  ufsm_upper_s upper;
  int fail_count = 0;
  int checked = 0;

  // Walk through every state and event kind
  ufsm_row_s rows [0:24] = '{
    '{3'h1, 1'b0, upstream_access_fault, 5'h02, 5'h00, 1'b0, 1'b0},
    '{3'h0, 1'b0, user_operational, 5'h00, 5'h02, 1'b1, 1'b0},
    '{3'h5, 1'b0, combined_access_link_fault, 5'h18, 5'h00, 1'b0, 1'b1},
    '{3'h0, 1'b0, user_operational, 5'h00, 5'h18, 1'b1, 1'b0},
    '{3'h3, 1'b0, downstream_access_fault, 5'h08, 5'h00, 1'b0, 1'b1},
    '{3'h4, 1'b0, upstream_link_fault, 5'h10, 5'h00, 1'b0, 1'b0},
    '{3'h3, 1'b0, downstream_access_fault, 5'h08, 5'h00, 1'b0, 1'b0},
    '{3'h5, 1'b0, combined_access_link_fault, 5'h10, 5'h00, 1'b0, 1'b0},
    '{3'h1, 1'b0, combined_access_link_fault, 5'h00, 5'h00, 1'b0, 1'b0},
    '{3'h2, 1'b0, downstream_link_fault, 5'h04, 5'h00, 1'b0, 1'b0},
    '{3'h3, 1'b0, downstream_link_fault, 5'h00, 5'h00, 1'b0, 1'b0},
    '{3'h0, 1'b0, user_operational, 5'h00, 5'h04, 1'b1, 1'b0},
    '{3'h4, 1'b0, upstream_link_fault, 5'h10, 5'h00, 1'b0, 1'b1},
    '{3'h5, 1'b0, combined_access_link_fault, 5'h08, 5'h00, 1'b0, 1'b0},
    '{3'h0, 1'b0, user_operational, 5'h00, 5'h18, 1'b1, 1'b0},
    '{3'h1, 1'b0, upstream_access_fault, 5'h02, 5'h00, 1'b0, 1'b1},
    '{3'h7, 1'b0, downstream_access_fault, 5'h08, 5'h00, 1'b0, 1'b0},
    '{3'h0, 1'b0, user_operational, 5'h00, 5'h08, 1'b1, 1'b0},
    '{3'h2, 1'b1, user_power_off, 5'h01, 5'h00, 1'b0, 1'b1},
    '{3'h6, 1'b0, user_power_on, 5'h00, 5'h00, 1'b0, 1'b0},
    '{3'h5, 1'b0, combined_access_link_fault, 5'h18, 5'h00, 1'b0, 1'b0},
    '{3'h2, 1'b0, downstream_link_fault, 5'h04, 5'h00, 1'b0, 1'b0},
    '{3'h0, 1'b0, user_operational, 5'h00, 5'h04, 1'b1, 1'b0},
    '{3'h2, 1'b0, downstream_link_fault, 5'h04, 5'h00, 1'b0, 1'b1},
    '{3'h6, 1'b1, user_power_off, 5'h01, 5'h00, 1'b0, 1'b0}
  };

  // Far side and block under test
  ufsm_net_model net (.i_mode(mode), .i_alt(alt), .o_defect(defect), .o_k2(k2), .o_g1(g1), .o_frame_ok(frame_ok));
  ufsm_fault_fsm uut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_power_good(pg), .i_powerdown(pd),
    .i_defect(defect), .i_apid_check_en(apid_en), .i_rx_k2(k2), .i_rx_g1(g1), .i_rx_frame_ok(frame_ok),
    .o_state(state), .o_tx(tx), .o_mgmt(mgmt), .o_upper(upper));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Transmit selection expected per state
  function automatic ufsm_tx_s tx_for(input ufsm_state_e s);
    ufsm_tx_s t;
    t = UFSM_TX_RESET;
    t.tx_on = (s != user_power_off) && (s != user_power_on);
    t.g1_rdi = s inside {downstream_access_fault, combined_access_link_fault, downstream_link_fault};
    if (s == downstream_link_fault) begin
      t.k2_bits = UFSM_MS_RDI_CODE;
    end
    return t;
  endfunction

  // Compare tasks
  task automatic cmp_state(input string what, input ufsm_state_e exp, input ufsm_state_e got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bits(input string what, input logic [10:0] exp, input logic [10:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Check all outputs against one expectation
  task automatic expect_out(input ufsm_state_e st, input logic [4:0] err, input logic [4:0] cor,
      input logic act, input logic dea);
    cmp_state("state", st, state);
    cmp_bits("tx", 11'(tx_for(st)), 11'(tx));
    cmp_bits("mgmt", {act, err, cor}, mgmt);
    cmp_bits("upper", {9'h000, act, dea}, 11'(upper));
  endtask

  // Drive inputs just after an edge, then pass one edge
  task automatic apply(input logic [2:0] m, input logic p);
    mode = m;
    pd = p;
    @(posedge clk);
    #1;
  endtask

  // Power good seen three edges late, no pulse on entry
  task automatic power_up();
    repeat (2) apply(3'h6, 1'b0);
    expect_out(user_power_off, 5'h00, 5'h00, 1'b0, 1'b0);
    apply(3'h6, 1'b0);
    expect_out(user_power_on, 5'h00, 5'h00, 1'b0, 1'b0);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #4000;
    fail_count++;
    $display("MISMATCH watchdog expected done seen timeout");
    tally_and_finish();
  end

  // Main sequence
  initial begin
    rst_b = 1'b0;
    pg = 1'b1;
    pd = 1'b0;
    apid_en = 1'b1;
    alt = 1'b0;
    mode = 3'h6;
    repeat (20) @(posedge clk);
    #1;
    rst_b = 1'b1;
    power_up();
    $display("test power up done");
    foreach (rows[i]) begin
      apply(rows[i].m, rows[i].p);
      expect_out(rows[i].st, rows[i].err, rows[i].cor, rows[i].act, rows[i].dea);
      apply(rows[i].m, rows[i].p);
      expect_out(rows[i].st, 5'h00, 5'h00, 1'b0, 1'b0);
      $display("test row %0d done", i);
    end
    // Asynchronous reset in mid-cycle from operation
    apply(3'h6, 1'b0);
    apply(3'h0, 1'b0);
    expect_out(user_operational, 5'h00, 5'h00, 1'b1, 1'b0);
    rst_b = 1'b0;
    #1;
    expect_out(user_power_off, 5'h00, 5'h00, 1'b0, 1'b0);
    @(posedge clk);
    #1;
    rst_b = 1'b1;
    power_up();
    $display("test mid reset done");
    // Power good pin dropping while operational
    apply(3'h0, 1'b0);
    pg = 1'b0;
    repeat (2) apply(3'h0, 1'b0);
    expect_out(user_operational, 5'h00, 5'h00, 1'b0, 1'b0);
    apply(3'h0, 1'b0);
    expect_out(user_power_off, 5'h01, 5'h00, 1'b0, 1'b1);
    pg = 1'b1;
    power_up();
    $display("test power pin done");
    // Identifier check off, then LOP with RDI, LCD combined and LOF
    apply(3'h0, 1'b0);
    expect_out(user_operational, 5'h00, 5'h00, 1'b1, 1'b0);
    apid_en = 1'b0;
    apply(3'h7, 1'b0);
    expect_out(user_operational, 5'h00, 5'h00, 1'b0, 1'b0);
    apid_en = 1'b1;
    alt = 1'b1;
    apply(3'h3, 1'b0);
    expect_out(downstream_access_fault, 5'h08, 5'h00, 1'b0, 1'b1);
    apply(3'h3, 1'b0);
    expect_out(downstream_access_fault, 5'h00, 5'h00, 1'b0, 1'b0);
    apply(3'h7, 1'b0);
    expect_out(combined_access_link_fault, 5'h10, 5'h00, 1'b0, 1'b0);
    apply(3'h2, 1'b0);
    expect_out(downstream_link_fault, 5'h04, 5'h00, 1'b0, 1'b0);
    alt = 1'b0;
    apply(3'h0, 1'b0);
    expect_out(user_operational, 5'h00, 5'h04, 1'b1, 1'b0);
    $display("test detector variants done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
